// File: core/eipm_ctrl.sv
// Purpose: External interrupt routing and sensing, plus RUN/SLOW/WAIT/HALT control, as an APB slave
// Assumes: pclk is the always-on clock; the core clock and peripheral clocks are gated by the enables
// Notes:   No wait state on any APB access; outputs all come from the state register
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "eipm_map.svh"

module eipm_ctrl
    import eipm_pkg::*;
(
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // APB slave
    input  wire eipm_apb_req_s  apb_i,
    output      eipm_apb_rsp_s  apb_o,
    // Processor core
    input  wire eipm_core_in_s  core_i,
    output      eipm_core_out_s core_o,
    // Option bits
    input  wire eipm_opt_s      opt_i,
    // Port pins carrying interrupt requests
    input  wire logic [7:0]     port_a,
    input  wire logic [6:0]     port_b
);

    eipm_state_s           s_q;
    eipm_state_s           s_d;

    logic [`EIPM_NSRC-1:0] evt_v;
    logic [`EIPM_NSRC-1:0] lvl_v;
    logic [`EIPM_NSRC-1:0] act_v;
    logic [`EIPM_NSRC-1:0] chg_v;
    logic                  halt_dec;
    logic                  wake_h;
    logic                  wake_w;

    function automatic logic [1:0] eipm_fld(input logic [7:0] v, input int n);
        return v[n*`EIPM_FLD_W +: `EIPM_FLD_W];
    endfunction : eipm_fld

    // Returns {valid, level}; an unrouted source reads as an idle high pin
    function automatic logic [1:0] eipm_pick(input logic [`EIPM_PIN_W-1:0] p,
                                             input logic [1:0]             src,
                                             input logic [1:0]             code);
        logic [3:0] idx;
        logic       ok;
        idx = `EIPM_PA0_IDX;
        ok  = 1'b1;
        if (src == `EIPM_SRC_ZERO)
        begin
            idx = 4'(`EIPM_PA0_IDX + {2'h0, code});
        end
        else if (src == `EIPM_SRC_ONE)
        begin
            idx = 4'(`EIPM_PA4_IDX + {2'h0, code});
        end
        else if (src == `EIPM_SRC_TWO)
        begin
            idx = 4'(`EIPM_PB3_IDX + {2'h0, code});
        end
        else
        begin
            idx = 4'(`EIPM_PB0_IDX + {2'h0, code});
            ok  = (code != `EIPM_ROUTE_NONE);
        end
        return {ok, ok ? p[idx] : 1'b1};
    endfunction : eipm_pick

    always_comb
    begin
        logic [1:0]             cur;
        logic [1:0]             old;
        logic [1:0]             sens;
        logic                   rise;
        logic                   fall;
        logic                   ev;
        logic                   setup;
        logic                   access;
        logic                   wr;
        logic                   tick;
        logic [`EIPM_NSRC-1:0]  clr;
        logic [`EIPM_DATA_W-1:0] rdata;
        logic                   err;
        cur      = 2'h0;
        old      = 2'h0;
        sens     = 2'h0;
        rise     = 1'b0;
        fall     = 1'b0;
        ev       = 1'b0;
        clr      = '0;
        rdata    = '0;
        err      = 1'b0;
        setup    = 1'b0;
        access   = 1'b0;
        wr       = 1'b0;
        tick     = 1'b0;
        evt_v    = '0;
        lvl_v    = '0;
        chg_v    = '0;
        s_d      = s_q;

        // Pins pass two flops before anything looks at them
        s_d.sync1 = {port_b, port_a};
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        s_d.opt   = opt_i;

        setup  = apb_i.psel && !apb_i.penable;
        access = apb_i.psel && apb_i.penable && s_q.apb.pready;
        wr     = access && apb_i.pwrite && !s_q.apb.pslverr;

        // Per-source routing, sensing and change detection
        for (int n = 0; n < `EIPM_NSRC; n++)
        begin
            cur  = eipm_pick(s_q.sync2, 2'(n), eipm_fld(s_q.route, n));
            old  = eipm_pick(s_q.prev, 2'(n), eipm_fld(s_q.route, n));
            rise = cur[0] && !old[0];
            fall = !cur[0] && old[0];
            sens = eipm_fld(s_q.sense, n);
            case (sens)
                `EIPM_SENSE_LOW:  ev = fall;
                `EIPM_SENSE_RISE: ev = rise;
                `EIPM_SENSE_FALL: ev = fall;
                default:          ev = rise || fall;
            endcase
            lvl_v[n] = (sens == `EIPM_SENSE_LOW) && cur[1] && !cur[0];
            if (2'(n) == `EIPM_SRC_TWO && s_q.mode == EIPM_HALT &&
                eipm_fld(s_q.route, n) == `EIPM_ROUTE_PB4)
            begin
                ev       = 1'b0;
                lvl_v[n] = 1'b0;
            end
            evt_v[n] = ev && cur[1];
            chg_v[n] = wr && core_i.i_bit && apb_i.paddr == `EIPM_OFF_SENSE &&
                       eipm_fld(apb_i.pwdata[7:0], n) != sens;
        end

        // Service entry or a sensitivity change clears; a new event wins
        clr    = core_i.irq_ack | chg_v;
        s_d.pend = (s_q.pend & ~clr) | evt_v;
        act_v  = s_d.pend | lvl_v;

        // APB read decode in the setup cycle; answer in the first access cycle
        s_d.apb.pready = setup;
        if (setup)
        begin
            if (apb_i.paddr == `EIPM_OFF_SENSE)
            begin
                rdata = 32'(s_q.sense);
            end
            else if (apb_i.paddr == `EIPM_OFF_ROUTE)
            begin
                rdata = 32'(s_q.route);
            end
            else if (apb_i.paddr == `EIPM_OFF_PWR)
            begin
                rdata[`EIPM_PWR_SLOW]  = s_q.slow;
                rdata[`EIPM_PWR_AWAKE] = s_q.auto_wake;
                rdata[`EIPM_PWR_AHALT] = s_q.active_halt;
            end
            else if (apb_i.paddr == `EIPM_OFF_STATUS)
            begin
                rdata[`EIPM_NSRC-1:0] = act_v;
                rdata[`EIPM_STS_MODE_LSB +: 3] = s_q.mode;
                rdata[`EIPM_STS_SLOW] = s_q.slow;
            end
            else
            begin
                err = 1'b1;
            end
            s_d.apb.prdata  = rdata;
            s_d.apb.pslverr = err;
        end

        // APB writes take effect at the access edge only
        if (wr)
        begin
            if (apb_i.paddr == `EIPM_OFF_SENSE)
            begin
                if (core_i.i_bit)
                begin
                    s_d.sense = apb_i.pwdata[7:0];
                end
            end
            else if (apb_i.paddr == `EIPM_OFF_ROUTE)
            begin
                s_d.route = apb_i.pwdata[7:0];
            end
            else if (apb_i.paddr == `EIPM_OFF_PWR)
            begin
                s_d.slow        = apb_i.pwdata[`EIPM_PWR_SLOW];
                s_d.auto_wake   = apb_i.pwdata[`EIPM_PWR_AWAKE];
                s_d.active_halt = apb_i.pwdata[`EIPM_PWR_AHALT];
            end
        end

        // Power mode sequencing
        halt_dec = core_i.instr_valid && core_i.opcode == `EIPM_HALT_OPCODE;
        wake_h   = (|act_v) || core_i.other_wake;
        wake_w   = (|act_v) || core_i.other_irq;
        s_d.out.i_clear   = 1'b0;
        s_d.out.wdg_reset = 1'b0;
        case (s_q.mode)
            EIPM_RUN:
            begin
                if (halt_dec)
                begin
                    // Active halt and auto wake belong to other logic; here HALT is a no-op
                    if (!s_q.active_halt && !s_q.auto_wake)
                    begin
                        if (s_q.opt.watchdog_active && !s_q.opt.watchdog_in_halt_option)
                        begin
                            s_d.out.wdg_reset = 1'b1;
                        end
                        else
                        begin
                            s_d.mode        = EIPM_HALT;
                            s_d.out.i_clear = 1'b1;
                        end
                    end
                end
                else if (core_i.wfi_exec)
                begin
                    s_d.mode        = EIPM_WAIT;
                    s_d.out.i_clear = 1'b1;
                end
            end
            EIPM_WAIT:
            begin
                if (wake_w)
                begin
                    s_d.mode = EIPM_RUN;
                end
            end
            EIPM_HALT:
            begin
                if (wake_h)
                begin
                    s_d.mode = EIPM_RESTART;
                    s_d.cnt  = s_q.opt.long_startup ? `EIPM_START_LONG : `EIPM_START_SHORT;
                end
            end
            EIPM_RESTART:
            begin
                s_d.cnt = `EIPM_CNT_W'(s_q.cnt - 1'b1);
                if (s_q.cnt == '0)
                begin
                    if (s_q.opt.pll_enable)
                    begin
                        s_d.mode = EIPM_PLL_START;
                        s_d.cnt  = `EIPM_CNT_W'(`EIPM_PLL_CYC - 1);
                    end
                    else
                    begin
                        s_d.mode = EIPM_RUN;
                    end
                end
            end
            default:
            begin
                s_d.cnt = `EIPM_CNT_W'(s_q.cnt - 1'b1);
                if (s_q.cnt == '0)
                begin
                    s_d.mode = EIPM_RUN;
                end
            end
        endcase

        // Clock divider is held in HALT so SLOW restarts cleanly after wake-up
        s_d.div = (s_d.mode == EIPM_HALT) ? '0 : `EIPM_DIV_W'(s_q.div + 1'b1);
        tick    = !s_d.slow || s_d.div == `EIPM_DIV_LAST;

        s_d.out.mode          = s_d.mode;
        s_d.out.osc_on        = s_d.mode != EIPM_HALT;
        s_d.out.cpu_clk_en    = s_d.mode == EIPM_RUN && tick;
        s_d.out.periph_clk_en = (s_d.mode == EIPM_RUN || s_d.mode == EIPM_WAIT) && tick;
        s_d.out.pll_clk_ready = s_q.opt.pll_enable &&
                                (s_d.mode == EIPM_RUN || s_d.mode == EIPM_WAIT);
        // Requests reach the core only once it runs again and is unmasked
        s_d.out.irq_req = (s_d.mode == EIPM_RUN && !core_i.i_bit) ? act_v : '0;
        s_d.out.cc_push = |core_i.irq_ack;
        s_d.out.i_set   = |core_i.irq_ack;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q       <= '0;
            s_q.sense <= `EIPM_SENSE_RST;
            s_q.route <= `EIPM_ROUTE_RST;
            s_q.sync1 <= `EIPM_PINS_IDLE;
            s_q.sync2 <= `EIPM_PINS_IDLE;
            s_q.prev  <= `EIPM_PINS_IDLE;
            s_q.mode  <= EIPM_RUN;
            s_q.out.mode   <= EIPM_RUN;
            s_q.out.osc_on <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign apb_o  = s_q.apb;
    assign core_o = s_q.out;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_sense_write_gate: assert property (apb_i.psel && apb_i.penable && s_q.apb.pready && apb_i.pwrite &&
                                         apb_i.paddr == `EIPM_OFF_SENSE && !core_i.i_bit |=> $stable(s_q.sense))
        else $error("sensitivity changed while mask bit clear");

    a_sense_change_clear: assert property (|(chg_v & ~evt_v) |=> (s_q.pend & $past(chg_v & ~evt_v)) == '0)
        else $error("pending request kept after sensitivity change");

    a_edge_latch: assert property (evt_v[1] |=> s_q.pend[1] ##1 (s_q.pend[1] || $past(core_i.irq_ack[1])
                                   || $past(chg_v[1])))
        else $error("edge event not latched");

    a_masked_hold: assert property (s_q.pend[1] && !core_i.irq_ack[1] && !chg_v[1] |=> s_q.pend[1])
        else $error("masked request lost");

    a_level_request: assert property (lvl_v[1] && !core_i.i_bit && s_d.mode == EIPM_RUN |=> core_o.irq_req[1])
        else $error("low level not requesting");

    a_slow_divide: assert property (core_o.cpu_clk_en && s_q.slow |=> (!core_o.cpu_clk_en || !s_q.slow)[*8])
        else $error("slow clock enable too frequent");

    a_wait_wake: assert property (s_q.mode == EIPM_WAIT && wake_w |=> s_q.mode == EIPM_RUN)
        else $error("wait not left on interrupt");

    a_halt_entry: assert property (s_q.mode == EIPM_RUN && halt_dec && !s_q.active_halt && !s_q.auto_wake &&
                                   !(s_q.opt.watchdog_active && !s_q.opt.watchdog_in_halt_option)
                                   |=> s_q.mode == EIPM_HALT && core_o.i_clear && !core_o.osc_on)
        else $error("halt entry wrong");

    a_halt_clocks_off: assert property (s_q.mode == EIPM_HALT |-> !core_o.osc_on && !core_o.cpu_clk_en
                                        && !core_o.periph_clk_en)
        else $error("clock running in halt");

    a_wdg_halt_reset: assert property (core_o.wdg_reset |-> s_q.mode == EIPM_RUN && $past(halt_dec))
        else $error("watchdog reset without halt");

    a_restart_short: assert property ($rose(s_q.mode == EIPM_RESTART) && !s_q.opt.long_startup
                                      |-> ##255 (s_q.mode == EIPM_RESTART) ##1 (s_q.mode != EIPM_RESTART))
        else $error("short restart delay wrong");

    // The clock is held back for the whole start time so the core never sees an unlocked clock
    a_pll_delay: assert property ($rose(s_q.mode == EIPM_PLL_START)
                                  |-> ##24 (s_q.mode == EIPM_PLL_START) ##1 (s_q.mode == EIPM_RUN))
        else $error("pll start delay wrong");

    a_service_push: assert property (|core_i.irq_ack |=> core_o.cc_push && core_o.i_set)
        else $error("no condition code push on service entry");

endmodule : eipm_ctrl

// File: core/eipm_map.svh
// Purpose: Named offsets, fields, reset values and timing counts of the interrupt and power block
// Assumes: 25 MHz pclk; APB word addresses on a 12-bit byte address
// Notes:   Included by the package and the design module
`ifndef EIPM_MAP_SVH
`define EIPM_MAP_SVH

// Register byte offsets
`define EIPM_OFF_SENSE      12'h000
`define EIPM_OFF_ROUTE      12'h004
`define EIPM_OFF_PWR        12'h008
`define EIPM_OFF_STATUS     12'h00c

// Reset values
`define EIPM_SENSE_RST      8'h00
`define EIPM_ROUTE_RST      8'h0c
`define EIPM_PINS_IDLE      15'h7fff

// Bus, counter, field and pin widths, and the count of sources
`define EIPM_ADDR_W         12
`define EIPM_DATA_W         32
`define EIPM_PIN_W          15
`define EIPM_NSRC           4
`define EIPM_FLD_W          2
`define EIPM_CNT_W          12
`define EIPM_DIV_W          5

// Sensitivity codes
`define EIPM_SENSE_LOW      2'h0
`define EIPM_SENSE_RISE     2'h1
`define EIPM_SENSE_FALL     2'h2
`define EIPM_SENSE_BOTH     2'h3

// Source numbers, route codes and pin indices in {port_b, port_a}
`define EIPM_SRC_ZERO       2'h0
`define EIPM_SRC_ONE        2'h1
`define EIPM_SRC_TWO        2'h2
`define EIPM_SRC_THREE      2'h3
`define EIPM_PA0_IDX        4'h0
`define EIPM_PA4_IDX        4'h4
`define EIPM_PB0_IDX        4'h8
`define EIPM_PB3_IDX        4'hb
`define EIPM_ROUTE_NONE     2'h3
`define EIPM_ROUTE_PB4      2'h1

// Power control register bits
`define EIPM_PWR_SLOW       0
`define EIPM_PWR_AWAKE      1
`define EIPM_PWR_AHALT      2

// Status register field positions
`define EIPM_STS_MODE_LSB   4
`define EIPM_STS_SLOW       7

// Opcode and timing
`define EIPM_HALT_OPCODE    8'h8e
`define EIPM_DIV_LAST       5'h1f
`define EIPM_START_SHORT    12'h0ff
`define EIPM_START_LONG     12'hfff
`define EIPM_CLK_NS         40
`define EIPM_PLL_START_NS   1000
`define EIPM_PLL_CYC        ((`EIPM_PLL_START_NS + `EIPM_CLK_NS - 1) / `EIPM_CLK_NS)

`endif

// File: core/eipm_pkg.sv
// Purpose: Types shared by the interrupt front end and power mode control
// Assumes: Constants come from eipm_map.svh
// Notes:   All state of the design module is the one packed struct below
`include "eipm_map.svh"

package eipm_pkg;

    typedef enum logic [2:0] {
        EIPM_RUN,
        EIPM_WAIT,
        EIPM_HALT,
        EIPM_RESTART,
        EIPM_PLL_START
    } eipm_mode_e;

    typedef struct packed {
        logic                      psel;
        logic                      penable;
        logic                      pwrite;
        logic [`EIPM_ADDR_W-1:0]   paddr;
        logic [`EIPM_DATA_W-1:0]   pwdata;
    } eipm_apb_req_s;

    typedef struct packed {
        logic [`EIPM_DATA_W-1:0]   prdata;
        logic                      pready;
        logic                      pslverr;
    } eipm_apb_rsp_s;

    typedef struct packed {
        logic                      i_bit;
        logic                      instr_valid;
        logic [7:0]                opcode;
        logic                      wfi_exec;
        logic [`EIPM_NSRC-1:0]     irq_ack;
        logic                      other_irq;
        logic                      other_wake;
    } eipm_core_in_s;

    typedef struct packed {
        logic                      watchdog_active;
        logic                      watchdog_in_halt_option;
        logic                      pll_enable;
        logic                      long_startup;
    } eipm_opt_s;

    typedef struct packed {
        logic [`EIPM_NSRC-1:0]     irq_req;
        logic                      cc_push;
        logic                      i_set;
        logic                      i_clear;
        logic                      wdg_reset;
        logic                      cpu_clk_en;
        logic                      periph_clk_en;
        logic                      osc_on;
        logic                      pll_clk_ready;
        eipm_mode_e                mode;
    } eipm_core_out_s;

    typedef struct packed {
        logic [7:0]                sense;
        logic [7:0]                route;
        logic                      slow;
        logic                      auto_wake;
        logic                      active_halt;
        eipm_opt_s                 opt;
        eipm_mode_e                mode;
        logic [`EIPM_CNT_W-1:0]    cnt;
        logic [`EIPM_DIV_W-1:0]    div;
        logic [`EIPM_PIN_W-1:0]    sync1;
        logic [`EIPM_PIN_W-1:0]    sync2;
        logic [`EIPM_PIN_W-1:0]    prev;
        logic [`EIPM_NSRC-1:0]     pend;
        eipm_apb_rsp_s             apb;
        eipm_core_out_s            out;
    } eipm_state_s;

endpackage : eipm_pkg

// File: verification/eipm_core_mdl.sv
// Purpose: Core model that enters a routine for each request it sees
// Assumes: Requests are levels in the pclk domain
// Notes:   One ack pulse at a time, lowest source first, like a fixed priority
`timescale 1ns/100ps
module eipm_core_mdl
    import eipm_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Requests in, routine entry out
    input  wire logic [3:0] irq_req,
    output      logic [3:0] irq_ack
);
    // Idle cycle between acks lets the cleared request settle first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_ack <= 4'h0;
        else
            irq_ack <= (irq_ack == 4'h0) ? (irq_req & (~irq_req + 4'h1)) : 4'h0;
    end
endmodule : eipm_core_mdl

// File: verification/tb.sv
// Purpose: Register, interrupt and power mode tests of the interrupt and power block
// Assumes: APB answers in the first access cycle, with no wait state; options change only between tests
// Notes:   Core acks come from the core model
`timescale 1ns/100ps
`include "eipm_map.svh"
module tb
    import eipm_pkg::*;
;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    eipm_apb_req_s  req = '0;
    eipm_apb_rsp_s  rsp;
    eipm_core_in_s  cv = '0;
    eipm_core_in_s  cw;
    eipm_core_out_s co;
    eipm_opt_s      opt = '0;
    logic [3:0]     ack;
    logic [7:0]     pa = 8'hff;
    logic [6:0]     pb = 7'h7f;
    logic [31:0]    rd;
    logic           err;
    int             failures = 0;
    int             num_checks = 0;
    int             n;

    always #20 pclk = ~pclk;
    always_comb
    begin
        cw = cv;
        cw.irq_ack = ack;
    end

    eipm_ctrl dut_u (.pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp), .core_i(cw), .core_o(co),
                     .opt_i(opt), .port_a(pa), .port_b(pb));
    eipm_core_mdl core_u (.pclk(pclk), .presetn(presetn), .irq_req(co.irq_req), .irq_ack(ack));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wait_req(input int s, input logic v);
        n = 0;
        while (co.irq_req[s] !== v && n < 12)
        begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_req

    task automatic wait_mode(input eipm_mode_e m, input int lim);
        n = 0;
        while (co.mode !== m && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_mode

    task automatic op(input logic h);
        @(posedge pclk);
        cv.instr_valid <= h;
        cv.opcode <= `EIPM_HALT_OPCODE;
        cv.wfi_exec <= !h;
        @(posedge pclk);
        cv.instr_valid <= 1'b0;
        cv.wfi_exec <= 1'b0;
    endtask : op

    task give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    initial
    begin
        #(20000 * 40);
        failures++;
        give_verdict();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cv.i_bit <= 1'b1;
        chk(co.mode, EIPM_RUN);
        apb(0, `EIPM_OFF_SENSE, 0); chk(rd, 32'h0000_0000);
        apb(0, `EIPM_OFF_ROUTE, 0); chk(rd, 32'h0000_000c);
        cv.i_bit <= 1'b0;
        apb(1, `EIPM_OFF_SENSE, 32'h0000_0008);
        apb(0, `EIPM_OFF_SENSE, 0); chk(rd, 32'h0000_0000);
        cv.i_bit <= 1'b1;
        apb(1, `EIPM_OFF_SENSE, 32'h0000_0008);
        apb(0, `EIPM_OFF_SENSE, 0); chk(rd, 32'h0000_0008);
        apb(1, `EIPM_OFF_ROUTE, 32'h0000_001c);
        apb(0, `EIPM_OFF_ROUTE, 0); chk(rd, 32'h0000_001c);
        apb(0, 12'h010, 0); chk(rd, 32'h0000_0000); chk(err, 1'b1);
        // Masked falling edge on the default source one pin stays latched
        pa[7] <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(co.irq_req[1], 1'b0);
        apb(0, `EIPM_OFF_STATUS, 0); chk(rd[1], 1'b1);
        cv.i_bit <= 1'b0;
        wait_req(1, 1'b1); chk(co.irq_req[1], 1'b1);
        wait_req(1, 1'b0); chk(co.irq_req[1], 1'b0);
        chk({co.cc_push, co.i_set}, 2'b11);
        pa[7] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(co.irq_req[1], 1'b0);
        cv.i_bit <= 1'b1;
        pa[7] <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1, `EIPM_OFF_SENSE, 32'h0000_000c);
        apb(0, `EIPM_OFF_STATUS, 0); chk(rd[1], 1'b0);
        pa[7] <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(0, `EIPM_OFF_STATUS, 0); chk(rd[1], 1'b1);
        apb(1, `EIPM_OFF_SENSE, 32'h0000_0000);
        cv.i_bit <= 1'b0;
        pa[7] <= 1'b0;
        repeat (12) @(posedge pclk);
        chk(co.irq_req[1], 1'b1);
        pa[7] <= 1'b1;
        wait_req(1, 1'b0); chk(co.irq_req[1], 1'b0);
        apb(1, `EIPM_OFF_PWR, 32'h0000_0001);
        n = 0;
        repeat (64)
        begin
            @(posedge pclk);
            n += (co.cpu_clk_en === 1'b1);
        end
        chk(n, 2);
        // Waiting while slow keeps the divided clock on the peripherals only
        op(1'b0);
        n = 0;
        repeat (64)
        begin
            @(posedge pclk);
            n += (co.periph_clk_en === 1'b1) + 4 * (co.cpu_clk_en !== 1'b0);
        end
        chk(n, 2);
        cv.other_irq <= 1'b1;
        wait_mode(EIPM_RUN, 5); chk(co.mode, EIPM_RUN);
        cv.other_irq <= 1'b0;
        apb(1, `EIPM_OFF_PWR, 32'h0000_0000);
        op(1'b0);
        wait_mode(EIPM_WAIT, 5); chk(co.mode, EIPM_WAIT);
        chk({co.cpu_clk_en, co.periph_clk_en}, 2'b01);
        chk(co.i_clear, 1'b1);
        cv.other_irq <= 1'b1;
        wait_mode(EIPM_RUN, 5); chk(co.mode, EIPM_RUN);
        cv.other_irq <= 1'b0;
        // Auto wake set turns the halt opcode away
        apb(1, `EIPM_OFF_PWR, 32'h0000_0002);
        op(1'b1);
        repeat (4) @(posedge pclk);
        chk(co.mode, EIPM_RUN);
        // An active watchdog turns the halt into a watchdog reset until the option allows it
        opt.watchdog_active <= 1'b1;
        apb(1, `EIPM_OFF_PWR, 32'h0000_0000);
        op(1'b1);
        @(posedge pclk);
        chk(co.wdg_reset, 1'b1);
        chk(co.mode, EIPM_RUN);
        opt.watchdog_in_halt_option <= 1'b1;
        op(1'b1);
        wait_mode(EIPM_HALT, 5); chk(co.mode, EIPM_HALT);
        chk(co.i_clear, 1'b1);
        chk(co.osc_on, 1'b0);
        pb[4] <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(co.mode, EIPM_HALT);
        pa[0] <= 1'b0;
        wait_mode(EIPM_RESTART, 10); chk(co.osc_on, 1'b1);
        wait_mode(EIPM_RUN, 300); chk(n, 256);
        pa[0] <= 1'b1;
        pb[4] <= 1'b1;
        repeat (10) @(posedge pclk);
        // Long restart followed by the PLL start time
        opt.pll_enable   <= 1'b1;
        opt.long_startup <= 1'b1;
        op(1'b1);
        wait_mode(EIPM_HALT, 5); chk(co.pll_clk_ready, 1'b0);
        pa[0] <= 1'b0;
        wait_mode(EIPM_RESTART, 10);
        wait_mode(EIPM_PLL_START, 5000); chk(n, 4096);
        chk(co.pll_clk_ready, 1'b0);
        wait_mode(EIPM_RUN, 40); chk(n, 25);
        chk(co.pll_clk_ready, 1'b1);
        pa[0] <= 1'b1;
        repeat (10) @(posedge pclk);
        give_verdict();
    end
endmodule : tb
